// *** sdcb_bank_fsm.v ***
// Command decoder and per-bank state machine of a four-bank SDRAM.
// Assumes a controller on the pins; mode contents, data array outside.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "sdcb_defs.vh"

module sdcb_bank_fsm #(
    parameter ADDR_W = 12,
    parameter COL_W = 9,
    parameter LANES = 2,
    parameter [7:0] BURST_LEN = 8'h04
) (
    // Clock and reset
    input wire mclk_in,
    input wire rst_b_in,
    // Command pins
    input wire chip_select_n_in,
    input wire row_strobe_n_in,
    input wire column_strobe_n_in,
    input wire write_enable_n_in,
    input wire clock_enable_in,
    input wire [1:0] bank_select_in,
    input wire [ADDR_W-1:0] addr_in,
    input wire [LANES-1:0] data_mask_in,
    // Data lane control
    output reg [LANES-1:0] read_lane_en_out,
    output reg [LANES-1:0] write_lane_en_out,
    output reg array_write_out,
    output reg array_read_out,
    output reg [1:0] access_bank_out,
    output reg [COL_W-1:0] access_col_out,
    // Bank status
    output reg [23:0] bank_state_out,
    output reg [ADDR_W-1:0] open_row0_out,
    output reg [ADDR_W-1:0] open_row1_out,
    output reg [ADDR_W-1:0] open_row2_out,
    output reg [ADDR_W-1:0] open_row3_out,
    output reg [13:0] mode_reg_out,
    output reg [ADDR_W-1:0] refresh_row_out,
    output reg self_refresh_out,
    output reg deep_power_down_out,
    output reg illegal_cmd_out
);

// ----------------------------------------------------------------------
// Derived timing counts
// ----------------------------------------------------------------------
// Rounded up so a wait is never shorter than the analog time
localparam integer PRE_CYC_I = (`SDCB_PRECHARGE_TIME_PS +
    `SDCB_CLK_PERIOD_PS - 1) / `SDCB_CLK_PERIOD_PS;
localparam integer ACT_CYC_I = (`SDCB_ACT_ACCESS_TIME_PS +
    `SDCB_CLK_PERIOD_PS - 1) / `SDCB_CLK_PERIOD_PS;
localparam integer XSR_CYC_I = (`SDCB_SELF_REF_EXIT_TIME_PS +
    `SDCB_CLK_PERIOD_PS - 1) / `SDCB_CLK_PERIOD_PS;
localparam integer RFC_CYC_I = (`SDCB_REFRESH_TIME_PS +
    `SDCB_CLK_PERIOD_PS - 1) / `SDCB_CLK_PERIOD_PS;
localparam integer MRD_CYC_I = `SDCB_MODE_LOAD_TIME_CYC;
// Timers are 8 bits; waits beyond 255 cycles would need wider ones
localparam [7:0] PRE_CYC = PRE_CYC_I[7:0];
localparam [7:0] ACT_CYC = ACT_CYC_I[7:0];
localparam [7:0] XSR_CYC = XSR_CYC_I[7:0];
localparam [7:0] RFC_CYC = RFC_CYC_I[7:0];
localparam [7:0] MRD_CYC = MRD_CYC_I[7:0];

// One-hot bank states
localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_ACTG = 6'h02;
localparam [5:0] ST_ACT = 6'h04;
localparam [5:0] ST_RD = 6'h08;
localparam [5:0] ST_WR = 6'h10;
localparam [5:0] ST_PRE = 6'h20;

// ----------------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------------
reg [4:0] cmd_s1_q, cmd_s2_q;
reg [1:0] ba_s1_q, ba_s2_q;
reg [ADDR_W-1:0] a_s1_q, a_s2_q;
reg [LANES-1:0] dm_s1_q, dm_s2_q;

// Two stages on every pin; the first stage feeds only the second
// Bits of one command may land a cycle apart if a pin moves near the
// edge; the controller must drive all pins from one clock
always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        cmd_s1_q <= 5'h1f;
        cmd_s2_q <= 5'h1f;
        ba_s1_q <= 2'h0;
        ba_s2_q <= 2'h0;
        a_s1_q <= {ADDR_W{1'b0}};
        a_s2_q <= {ADDR_W{1'b0}};
        dm_s1_q <= {LANES{1'b1}};
        dm_s2_q <= {LANES{1'b1}};
    end else begin
        cmd_s1_q <= {clock_enable_in, chip_select_n_in, row_strobe_n_in,
                     column_strobe_n_in, write_enable_n_in};
        cmd_s2_q <= cmd_s1_q;
        ba_s1_q <= bank_select_in;
        ba_s2_q <= ba_s1_q;
        a_s1_q <= addr_in;
        a_s2_q <= a_s1_q;
        dm_s1_q <= data_mask_in;
        dm_s2_q <= dm_s1_q;
    end
end

// ----------------------------------------------------------------------
// Command decode
// ----------------------------------------------------------------------
reg cke_prev_q;
reg [5:0] st_q [0:3];
reg [7:0] tmr_q [0:3];
reg [7:0] burst_q [0:3];
reg [3:0] ap_q;
reg [7:0] glob_tmr_q;
reg [1:0] last_bank_q;
reg [LANES-1:0] dm_d1_q;
integer i;

// A command acts three edges after the pins, once synchronised;
// state outputs follow one edge after the decode
wire cke = cmd_s2_q[4];
wire [2:0] code = cmd_s2_q[2:0];
wire sel = ~cmd_s2_q[3];
wire ap = a_s2_q[`SDCB_AP_BIT];
wire low_power = self_refresh_out | deep_power_down_out;
// Table valid only with enable high now and before, and no global wait
wire run = cke & cke_prev_q & ~low_power & (glob_tmr_q == 8'h00);
wire exec = run & sel & (code != `SDCB_CMD_NOP);

// Returns 1 when all banks sit in the idle state
function all_idle;
    input [23:0] s;
    begin
        all_idle = (s[5:0] == ST_IDLE) && (s[11:6] == ST_IDLE) &&
                   (s[17:12] == ST_IDLE) && (s[23:18] == ST_IDLE);
    end
endfunction

// Returns 1 while a bank is moving burst data
function in_burst;
    input [5:0] s;
    begin
        in_burst = (s == ST_RD) || (s == ST_WR);
    end
endfunction

// Is the command listed for a bank in the given state
function legal;
    input [5:0] s;
    input [2:0] c;
    begin
        case (s)
            ST_IDLE: legal = (c == `SDCB_CMD_ACT) || (c == `SDCB_CMD_PRE);
            ST_ACT: legal = (c == `SDCB_CMD_RD) || (c == `SDCB_CMD_WR) ||
                            (c == `SDCB_CMD_PRE);
            ST_RD, ST_WR: legal = (c == `SDCB_CMD_RD) || (c == `SDCB_CMD_WR) ||
                            (c == `SDCB_CMD_PRE) || (c == `SDCB_CMD_BST);
            default: legal = 1'b0;
        endcase
    end
endfunction

wire [23:0] st_flat = {st_q[3], st_q[2], st_q[1], st_q[0]};
wire global_cmd = (code == `SDCB_CMD_REF) || (code == `SDCB_CMD_MRS);
wire pre_all = (code == `SDCB_CMD_PRE) & ap;
// Refresh and mode load need every bank idle at once;
// burst terminate is judged against the bank of the last access
wire ok = global_cmd ? all_idle(st_flat) :
          pre_all ? 1'b1 :
          (code == `SDCB_CMD_BST) ? legal(st_q[last_bank_q], code) :
          legal(st_q[ba_s2_q], code);

// ----------------------------------------------------------------------
// Bank state machines and global modes
// ----------------------------------------------------------------------
always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        for (i = 0; i < 4; i = i + 1) begin
            st_q[i] <= ST_IDLE;
            tmr_q[i] <= 8'h00;
            burst_q[i] <= 8'h00;
        end
        ap_q <= 4'h0;
        glob_tmr_q <= 8'h00;
        last_bank_q <= 2'h0;
        cke_prev_q <= 1'b0;
        mode_reg_out <= `SDCB_MODE_RESET;
        refresh_row_out <= {ADDR_W{1'b0}};
        self_refresh_out <= 1'b0;
        deep_power_down_out <= 1'b0;
        illegal_cmd_out <= 1'b0;
        open_row0_out <= {ADDR_W{1'b0}};
        open_row1_out <= {ADDR_W{1'b0}};
        open_row2_out <= {ADDR_W{1'b0}};
        open_row3_out <= {ADDR_W{1'b0}};
    end else begin
        cke_prev_q <= cke;
        illegal_cmd_out <= exec & ~ok;
        if (glob_tmr_q != 8'h00)
            glob_tmr_q <= glob_tmr_q - 8'h01;
        // Timed transitions and burst ends, per bank
        for (i = 0; i < 4; i = i + 1) begin
            if (tmr_q[i] != 8'h00)
                tmr_q[i] <= tmr_q[i] - 8'h01;
            else if (st_q[i] == ST_ACTG)
                st_q[i] <= ST_ACT;
            else if (st_q[i] == ST_PRE)
                st_q[i] <= ST_IDLE;
            if (in_burst(st_q[i]) && burst_q[i] != 8'h00) begin
                burst_q[i] <= burst_q[i] - 8'h01;
                if (burst_q[i] == 8'h01) begin
                    // Auto precharge closes the row at burst end
                    st_q[i] <= ap_q[i] ? ST_PRE : ST_ACT;
                    tmr_q[i] <= ap_q[i] ? PRE_CYC - 8'h01 : 8'h00;
                end
            end
        end
        // Self refresh and deep power-down exits on enable high
        // Entry with a row still open is dropped, not queued
        if (low_power && cke) begin
            self_refresh_out <= 1'b0;
            deep_power_down_out <= 1'b0;
            if (self_refresh_out)
                glob_tmr_q <= XSR_CYC;
        end else if (!low_power && !cke && cke_prev_q && sel &&
                     all_idle(st_flat)) begin
            // Low-power entry: enable falls with the command
            if (code == `SDCB_CMD_REF)
                self_refresh_out <= 1'b1;
            else if (code == `SDCB_CMD_BST)
                deep_power_down_out <= 1'b1;
        end
        if (exec && ok) begin
            case (code)
                `SDCB_CMD_MRS: begin
                    mode_reg_out <= {ba_s2_q, a_s2_q};
                    glob_tmr_q <= MRD_CYC;
                end
                `SDCB_CMD_REF: begin
                    // Row from the internal counter, address ignored
                    refresh_row_out <= refresh_row_out + 1'b1;
                    glob_tmr_q <= RFC_CYC;
                end
                `SDCB_CMD_ACT: begin
                    st_q[ba_s2_q] <= ST_ACTG;
                    tmr_q[ba_s2_q] <= ACT_CYC - 8'h01;
                    if (ba_s2_q == 2'h0) open_row0_out <= a_s2_q;
                    if (ba_s2_q == 2'h1) open_row1_out <= a_s2_q;
                    if (ba_s2_q == 2'h2) open_row2_out <= a_s2_q;
                    if (ba_s2_q == 2'h3) open_row3_out <= a_s2_q;
                end
                `SDCB_CMD_RD, `SDCB_CMD_WR: begin
                    st_q[ba_s2_q] <= (code == `SDCB_CMD_RD) ? ST_RD : ST_WR;
                    burst_q[ba_s2_q] <= BURST_LEN;
                    ap_q[ba_s2_q] <= ap;
                    last_bank_q <= ba_s2_q;
                end
                `SDCB_CMD_PRE: begin
                    // One bank or all; cuts any burst short
                    for (i = 0; i < 4; i = i + 1)
                        if (ap || ba_s2_q == i[1:0]) begin
                            st_q[i] <= ST_PRE;
                            tmr_q[i] <= PRE_CYC - 8'h01;
                            burst_q[i] <= 8'h00;
                        end
                end
                `SDCB_CMD_BST: begin
                    st_q[last_bank_q] <= ST_ACT;
                    burst_q[last_bank_q] <= 8'h00;
                end
                default: ;
            endcase
        end
    end
end

// ----------------------------------------------------------------------
// Data lane control
// ----------------------------------------------------------------------
reg [LANES-1:0] dm_d2_q;
wire rd_active = (st_q[last_bank_q] == ST_RD);
wire wr_active = (st_q[last_bank_q] == ST_WR);

// Read mask takes two clocks; write mask applies at once.
// The two extra stages keep read lanes two beats behind the write
// lanes for a mask sampled on the same edge.
always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        dm_d1_q <= {LANES{1'b1}};
        dm_d2_q <= {LANES{1'b1}};
        read_lane_en_out <= {LANES{1'b0}};
        write_lane_en_out <= {LANES{1'b0}};
        array_write_out <= 1'b0;
        array_read_out <= 1'b0;
        access_bank_out <= 2'h0;
        access_col_out <= {COL_W{1'b0}};
        bank_state_out <= 24'h041041;
    end else begin
        dm_d1_q <= dm_s2_q;
        dm_d2_q <= dm_d1_q;
        read_lane_en_out <= rd_active ? ~dm_d2_q : {LANES{1'b0}};
        write_lane_en_out <= wr_active ? ~dm_s2_q : {LANES{1'b0}};
        array_write_out <= wr_active & (|(~dm_s2_q));
        array_read_out <= rd_active;
        bank_state_out <= st_flat;
        if (exec && ok && (code == `SDCB_CMD_RD || code == `SDCB_CMD_WR)) begin
            access_bank_out <= ba_s2_q;
            access_col_out <= a_s2_q[COL_W-1:0];
        end else if (in_burst(st_q[last_bank_q])) begin
            access_col_out <= access_col_out + 1'b1;
        end
    end
end

endmodule // sdcb_bank_fsm

// *** sdcb_bank_fsm_sva.sv ***
// Checker for the bank state machine; sees the top module's ports only.
// Assumes the bind below and the design's default widths.
`timescale 1ns/1ps
module sdcb_bank_fsm_sva #(
    parameter LANES = 2
) (
    // Clock, reset and pins
    input wire mclk_in,
    input wire rst_b_in,
    input wire chip_select_n_in,
    input wire row_strobe_n_in,
    input wire column_strobe_n_in,
    input wire write_enable_n_in,
    input wire clock_enable_in,
    input wire [LANES-1:0] data_mask_in,
    // Outputs watched
    input wire [LANES-1:0] read_lane_en_out,
    input wire [LANES-1:0] write_lane_en_out,
    input wire array_write_out,
    input wire array_read_out,
    input wire [23:0] bank_state_out,
    input wire [13:0] mode_reg_out,
    input wire self_refresh_out,
    input wire deep_power_down_out
);
    logic mld;
    logic [2:0] mrs_q;
    // Recent mode load on the pins; window spans the sync pipe
    assign mld = !(chip_select_n_in | row_strobe_n_in |
                   column_strobe_n_in | write_enable_n_in);
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) mrs_q <= 3'h0;
        else if (mld) mrs_q <= 3'h7;
        else if (mrs_q != 3'h0) mrs_q <= mrs_q - 3'h1;
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    property p_act_one;
        bank_state_out[1] |=> bank_state_out[2];
    endproperty
    a_act_one: assert property (p_act_one)
        else $error("activating longer than one cycle");
    property p_pre_one;
        bank_state_out[17] |=> bank_state_out[12];
    endproperty
    a_pre_one: assert property (p_pre_one)
        else $error("precharging longer than one cycle");
    property p_idle_nob;
        bank_state_out[6] |=> !(bank_state_out[9] | bank_state_out[10]);
    endproperty
    a_idle_nob: assert property (p_idle_nob)
        else $error("idle bank jumped into a burst");
    // Idle outlives any command still in the pipe
    property p_nop_hold;
        chip_select_n_in [*6] ##0 bank_state_out[0] |=> bank_state_out[0];
    endproperty
    a_nop_hold: assert property (p_nop_hold)
        else $error("idle bank moved without a command");
    // Mask reaches the write lanes three edges after the pins
    property p_wmask;
        array_write_out |-> write_lane_en_out == ~$past(data_mask_in, 3);
    endproperty
    a_wmask: assert property (p_wmask)
        else $error("write lanes disagree with mask");
    // Read lanes lag the write lanes by two more edges
    property p_rmask;
        array_read_out |-> read_lane_en_out == ~$past(data_mask_in, 5);
    endproperty
    a_rmask: assert property (p_rmask)
        else $error("read lanes disagree with mask");
    property p_dpd_exit;
        clock_enable_in [*6] |-> !deep_power_down_out;
    endproperty
    a_dpd_exit: assert property (p_dpd_exit)
        else $error("deep power-down kept with enable high");
    property p_sref_hold;
        (!clock_enable_in) [*4] ##0 self_refresh_out |=> self_refresh_out;
    endproperty
    a_sref_hold: assert property (p_sref_hold)
        else $error("self refresh left with enable low");
    property p_mode_cause;
        $changed(mode_reg_out) |-> mrs_q != 3'h0;
    endproperty
    a_mode_cause: assert property (p_mode_cause)
        else $error("mode changed without a mode load");
    c_rd: cover property (array_read_out);
    c_wr: cover property (array_write_out);
    c_sref: cover property (self_refresh_out);
    c_dpd: cover property (deep_power_down_out);
endmodule // sdcb_bank_fsm_sva

bind sdcb_bank_fsm sdcb_bank_fsm_sva #(.LANES(LANES)) u_sva (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .chip_select_n_in(chip_select_n_in), .row_strobe_n_in(row_strobe_n_in),
    .column_strobe_n_in(column_strobe_n_in),
    .write_enable_n_in(write_enable_n_in), .clock_enable_in(clock_enable_in),
    .data_mask_in(data_mask_in), .read_lane_en_out(read_lane_en_out),
    .write_lane_en_out(write_lane_en_out), .array_write_out(array_write_out),
    .array_read_out(array_read_out), .bank_state_out(bank_state_out),
    .mode_reg_out(mode_reg_out), .self_refresh_out(self_refresh_out),
    .deep_power_down_out(deep_power_down_out));

// *** sdcb_bank_fsm_tb_top.sv ***
// Bench: controller model drives pins, bank states checked from a queue.
// Assumes default design widths and a 40 MHz clock.
`timescale 1ns/1ps
`include "sdcb_defs.vh"
module sdcb_bank_fsm_tb_top;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic req = 1'b0;
    logic [2:0] cmd = 3'h7;
    logic [1:0] ba = 2'h0;
    logic [11:0] adr = 12'h000;
    logic cke = 1'b1;
    logic [1:0] dm = 2'h0;
    logic [1:0] dmh [0:4];
    wire cs_n, cke_p, awr, ard, sref, deep_power_down, ill;
    wire [2:0] rcw_n;
    wire [1:0] ba_p, dm_p, rd_en, wr_en;
    wire [11:0] a_p, rrow;
    wire [11:0] row [0:3];
    wire [23:0] st;
    wire [13:0] mode;
    logic [23:0] sh = 24'h041041;
    logic [23:0] exp_q[$];
    int fails = 0;
    int n_compared = 0;
    int n_ill = 0;
    int n_wb = 0;
    bit live = 1'b0;
    always #12.5 mclk_in = ~mclk_in;
    sdcb_ctrl_model u_ctrl (.mclk_in(mclk_in), .req_in(req), .cmd_in(cmd),
        .ba_in(ba), .a_in(adr), .cke_in(cke), .dm_in(dm), .cs_n_out(cs_n),
        .rcw_n_out(rcw_n), .ba_out(ba_p), .a_out(a_p), .cke_out(cke_p),
        .dm_out(dm_p));
    sdcb_bank_fsm DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .chip_select_n_in(cs_n), .row_strobe_n_in(rcw_n[2]),
        .column_strobe_n_in(rcw_n[1]), .write_enable_n_in(rcw_n[0]),
        .clock_enable_in(cke_p), .bank_select_in(ba_p), .addr_in(a_p),
        .data_mask_in(dm_p), .read_lane_en_out(rd_en),
        .write_lane_en_out(wr_en), .array_write_out(awr),
        .array_read_out(ard), .access_bank_out(), .access_col_out(),
        .bank_state_out(st), .open_row0_out(row[0]), .open_row1_out(row[1]),
        .open_row2_out(row[2]), .open_row3_out(row[3]), .mode_reg_out(mode),
        .refresh_row_out(rrow), .self_refresh_out(sref),
        .deep_power_down_out(deep_power_down), .illegal_cmd_out(ill));
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // Waits move the mask too; both lanes masked never, so every
    // write beat reaches the array
    task automatic wt(input int n);
        repeat (n) begin
            @(posedge mclk_in);
            dm <= 2'($urandom % 3);
        end
        #1;
    endtask
    task automatic go(input logic [2:0] c, input logic [1:0] b,
                      input logic [11:0] a, input logic k, input int n);
        @(posedge mclk_in);
        req <= 1'b1;
        cmd <= c;
        ba <= b;
        adr <= a;
        cke <= k;
        @(posedge mclk_in);
        req <= 1'b0;
        wt(n);
    endtask
    task automatic put(input int b, input logic [5:0] s);
        sh[b*6 +: 6] = s;
        exp_q.push_back(sh);
    endtask
    task automatic complete_run;
        if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Every state change takes the oldest note off the queue
    always @(st) if (live) begin
        if (exp_q.size() == 0) chk("state_q", 0, 1);
        else chk("bank_state", exp_q.pop_front(), st);
    end
    // Mask as the design sampled it, one entry per edge
    always @(posedge mclk_in) begin
        dmh[0] <= dm_p;
        for (int k = 1; k < 5; k++) dmh[k] <= dmh[k-1];
    end
    // Mid-cycle sampling keeps clear of the output update
    always @(negedge mclk_in) begin
        if (ill === 1'b1) n_ill++;
        if (awr === 1'b1) n_wb++;
        if (awr === 1'b1) chk("wr_lanes", 2'(~dmh[2]), wr_en);
        if (ard === 1'b1) chk("rd_lanes", 2'(~dmh[4]), rd_en);
    end
    // Far beyond the planned few hundred cycles
    initial begin
        #75000;
        fails++;
        complete_run;
    end
    initial begin : main
        logic [13:0] m;
        logic [11:0] r;
        logic [11:0] r0;
        int i;
        void'($urandom(32'h42af33b9));
        wt(16);
        rst_b_in <= 1'b1;
        wt(4);
        live = 1'b1;
        chk("bank_state", 24'h041041, st);
        m = 14'($urandom);
        go(`SDCB_CMD_MRS, m[13:12], m[11:0], 1'b1, 8);
        chk("mode", m, mode);
        go(`SDCB_CMD_RD, 2'h1, 12'h000, 1'b1, 6);
        go(`SDCB_CMD_WR, 2'h2, 12'h400, 1'b1, 6);
        chk("illegal", 2, n_ill);
        // Per bank: random row, then read or write, some cut short
        for (i = 0; i < 4; i++) begin
            @(posedge mclk_in);
            dm <= 2'($urandom % 3);
            r = 12'($urandom);
            put(i, 6'h02);
            put(i, 6'h04);
            put(i, i[0] ? 6'h10 : 6'h08);
            put(i, i[0] ? 6'h04 : 6'h20);
            if (!i[0]) put(i, 6'h01);
            go(`SDCB_CMD_ACT, i[1:0], r, 1'b1, 8);
            chk("open_row", r, row[i]);
            go(i[0] ? `SDCB_CMD_WR : `SDCB_CMD_RD, i[1:0],
               {1'b0, i == 0, 1'b0, 9'($urandom)}, 1'b1, i < 2 ? 10 : 0);
            if (i >= 2) go(i == 2 ? `SDCB_CMD_PRE : `SDCB_CMD_BST, i[1:0],
                           12'h000, 1'b1, 10);
        end
        chk("write_beats", 1, n_wb > 4 && n_wb < 8);
        // Precharge all moves every bank, idle ones too, for one cycle
        sh[0 +: 18] = 18'h20820;
        put(3, 6'h20);
        sh[0 +: 18] = 18'h01041;
        put(3, 6'h01);
        go(`SDCB_CMD_PRE, 2'($urandom), 12'h400, 1'b1, 8);
        r0 = rrow;
        go(`SDCB_CMD_REF, 2'($urandom), 12'($urandom), 1'b1, 10);
        chk("refresh_row", r0 + 12'h1, rrow);
        go(`SDCB_CMD_REF, 2'h0, 12'h000, 1'b0, 8);
        chk("self_ref", 1, sref);
        @(posedge mclk_in);
        cke <= 1'b1;
        wt(12);
        chk("self_ref", 0, sref);
        go(`SDCB_CMD_BST, 2'h0, 12'h000, 1'b0, 8);
        chk("deep_pd", 1, deep_power_down);
        @(posedge mclk_in);
        cke <= 1'b1;
        wt(8);
        chk("deep_pd", 0, deep_power_down);
        chk("state_q", 0, exp_q.size());
        complete_run;
    end
endmodule // sdcb_bank_fsm_tb_top

// *** sdcb_ctrl_model.sv ***
// Memory controller model: puts one command on the pins per request.
// Assumes requests arrive registered on the rising edge.
`timescale 1ns/1ps
module sdcb_ctrl_model (
    // Requests from the bench
    input wire mclk_in,
    input wire req_in,
    input wire [2:0] cmd_in,
    input wire [1:0] ba_in,
    input wire [11:0] a_in,
    input wire cke_in,
    input wire [1:0] dm_in,
    // Pins toward the device
    output reg cs_n_out = 1'b1,
    output reg [2:0] rcw_n_out = 3'h7,
    output reg [1:0] ba_out = 2'h0,
    output reg [11:0] a_out = 12'h000,
    output reg cke_out = 1'b1,
    output reg [1:0] dm_out = 2'h0
);
    // Between commands: deselect, junk that changes every cycle
    always @(posedge mclk_in) begin
        cke_out <= cke_in;
        dm_out <= dm_in;
        if (req_in) begin
            cs_n_out <= 1'b0;
            rcw_n_out <= cmd_in;
            ba_out <= ba_in;
            a_out <= a_in;
        end else begin
            cs_n_out <= 1'b1;
            rcw_n_out <= ~rcw_n_out;
            ba_out <= ~ba_out;
            a_out <= ~a_out;
        end
    end
endmodule // sdcb_ctrl_model

// *** sdcb_defs.vh ***
// Constants of the four-bank command decoder and bank state machine.
// Assumes inclusion by bare name from the design file.
`ifndef SDCB_DEFS_VH
`define SDCB_DEFS_VH
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SDCB_CLK_PERIOD_PS 25000
`define SDCB_PRECHARGE_TIME_PS 18000
`define SDCB_ACT_ACCESS_TIME_PS 18000
`define SDCB_MODE_LOAD_TIME_CYC 2
`define SDCB_SELF_REF_EXIT_TIME_PS 112500
`define SDCB_REFRESH_TIME_PS 72000
// ----------------------------------------------------------------------
// Command codes {ras_n, cas_n, we_n}
// ----------------------------------------------------------------------
`define SDCB_CMD_NOP 3'h7
`define SDCB_CMD_ACT 3'h3
`define SDCB_CMD_RD 3'h5
`define SDCB_CMD_WR 3'h4
`define SDCB_CMD_BST 3'h6
`define SDCB_CMD_PRE 3'h2
`define SDCB_CMD_REF 3'h1
`define SDCB_CMD_MRS 3'h0
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SDCB_AP_BIT 10
`define SDCB_MODE_RESET 14'h0000
`endif
